// ---- hw/vu_pkg.sv ----
// Shared constants of the valve unit parameter blocks
package vu_pkg;
	// ----------------------------------------
	// Parameter addressing
	// ----------------------------------------
	// A parameter address is {block, parameter}, i.e. index = block * 8 + parameter
	localparam int BLK_W = 4;
	localparam int PAR_W = 3;
	localparam int ADR_W = BLK_W + PAR_W;
	localparam int WORD_W = 16;
	localparam logic [ADR_W-1:0] ADR_POS_MV      = 7'h20; // Block 4 parameter 0
	localparam logic [ADR_W-1:0] ADR_POS_DEV     = 7'h21;
	localparam logic [ADR_W-1:0] ADR_POS_TMO     = 7'h22;
	localparam logic [ADR_W-1:0] ADR_POS_CAL_LO  = 7'h23;
	localparam logic [ADR_W-1:0] ADR_POS_CAL_HI  = 7'h24;
	localparam logic [ADR_W-1:0] ADR_POS_RAW     = 7'h25;
	localparam logic [ADR_W-1:0] ADR_CTL_TARGET  = 7'h29; // Block 5 parameter 1
	localparam logic [ADR_W-1:0] ADR_CTL_HOLD    = 7'h2a;
	localparam logic [ADR_W-1:0] ADR_CTL_DBAND   = 7'h2b;
	localparam logic [ADR_W-1:0] ADR_CTL_HYST    = 7'h2c;
	localparam logic [ADR_W-1:0] ADR_RLY_STATE   = 7'h30; // Block 6 parameter 0
	localparam logic [ADR_W-1:0] ADR_RLY_OPEN    = 7'h31;
	localparam logic [ADR_W-1:0] ADR_RLY_STOP    = 7'h32;
	localparam logic [ADR_W-1:0] ADR_RLY_CLOSE   = 7'h33;
	localparam logic [ADR_W-1:0] ADR_RLY_ESD     = 7'h34;
	localparam logic [ADR_W-1:0] ADR_RLY_PST     = 7'h35;
	localparam logic [ADR_W-1:0] ADR_PULSE_COUNT = 7'h38; // Block 7 parameter 0
	// ----------------------------------------
	// Field layout of the relay state word
	// ----------------------------------------
	localparam int RLY_BIT_FOUR  = 0;
	localparam int RLY_BIT_ONE   = 1;
	localparam int RLY_BIT_THREE = 2;
	localparam int RLY_BIT_TWO   = 3;
	localparam int RLY_BIT_MODE  = 7;
	// ----------------------------------------
	// Reset values and ranges
	// ----------------------------------------
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	localparam logic [WORD_W-1:0] PULSE_MAX = 16'h270f; // 9999 decimal
	localparam int MV_W = 8;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam longint SECOND_NS     = 1000000000;
	localparam longint CLK_PERIOD_NS = 5;
	localparam int SEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

// ---- hw/vu_pos_if.sv ----
// Position report signals between the parameter bank and the report engine
`timescale 1ns/10ps
interface vu_pos_if;
	logic [7:0]  measured_value; // Current 8-bit position
	logic [15:0] threshold;      // Deviation threshold word
	logic [15:0] timeout;        // Update timeout word in seconds
	logic        report;         // One-cycle fresh report pulse
	modport bank (output measured_value, output threshold, output timeout, input report);
	modport engine (input measured_value, input threshold, input timeout, output report);
endinterface

// ---- hw/vu_pos_report.sv ----
// Position report engine: deviation and timed update
`timescale 1ns/10ps
module vu_pos_report
	import vu_pkg::*;
#(
	parameter int SEC_COUNT = SEC_CYCLES
)(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Position link to the bank
	vu_pos_if.engine  pos
);
	logic [7:0]  last_ff, nxt_last;     // Last reported position
	logic [31:0] tick_ff, nxt_tick;     // Cycles within one second
	logic [15:0] secs_ff, nxt_secs;     // Whole seconds since last report
	logic        report_ff, nxt_report; // Registered report pulse
	logic [7:0]  diff;                  // Absolute movement since report
	logic        dev_hit;
	logic        tmo_hit;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		diff = (pos.measured_value > last_ff) ? pos.measured_value - last_ff
			: last_ff - pos.measured_value;
		// Zero threshold disables deviation reporting
		dev_hit = (pos.threshold != WORD_ZERO) && (16'(diff) > pos.threshold);
		// Zero timeout disables timed reporting
		tmo_hit = (pos.timeout != WORD_ZERO) && (secs_ff >= pos.timeout);
		nxt_report = dev_hit || tmo_hit;
		nxt_last = last_ff;
		nxt_tick = tick_ff + 32'd1;
		nxt_secs = secs_ff;
		if (nxt_report)
		begin
			// Restart both measures from the new report
			nxt_last = pos.measured_value;
			nxt_tick = 32'd0;
			nxt_secs = WORD_ZERO;
		end
		else if (tick_ff >= 32'(SEC_COUNT - 1))
		begin
			// One whole second elapsed; saturate rather than wrap
			nxt_tick = 32'd0;
			if (secs_ff != 16'hffff)
				nxt_secs = secs_ff + 16'd1;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			last_ff   <= 8'h00;
			tick_ff   <= 32'h0000_0000;
			secs_ff   <= 16'h0000;
			report_ff <= 1'b0;
		end
		else
		begin
			last_ff   <= nxt_last;
			tick_ff   <= nxt_tick;
			secs_ff   <= nxt_secs;
			report_ff <= nxt_report;
		end
	end

	assign pos.report = report_ff;
endmodule // vu_pos_report

// ---- hw/vu_pulse_counter.sv ----
// Decimal-range pulse counter, 0 to 9999 then wraps
`timescale 1ns/10ps
module vu_pulse_counter
	import vu_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Synchronised pulse level
	input  wire logic        pulse_sync,
	// Count value
	output logic [15:0]      count
);
	logic        prev_ff, nxt_prev;   // Previous pulse level
	logic [15:0] count_ff, nxt_count; // Binary count

	// ----------------------------------------
	// Count on each rising edge of the pulse
	// ----------------------------------------
	always_comb
	begin
		nxt_prev  = pulse_sync;
		nxt_count = count_ff;
		if (pulse_sync && !prev_ff)
			nxt_count = (count_ff >= PULSE_MAX) ? WORD_ZERO : count_ff + 16'd1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			prev_ff  <= 1'b0;
			count_ff <= 16'h0000;
		end
		else
		begin
			prev_ff  <= nxt_prev;
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;
endmodule // vu_pulse_counter

// ---- hw/vu_param_bank.sv ----
// Parameter bank of the valve unit: position, control, relay and pulse blocks
//
// Functional notes
// - Deviation threshold RW, zero disables reporting
// - Update timeout RW seconds, zero disables
// - Calibration low/high RW, raw input RO
// - Target position RW, 0 closed 255 full
// - Motion hold RW, 255 means 128 s
// - Deadband RW, 255 means twelve percent
// - Relay state bits 4,1,3,2, mode bit7
// - Open command drives relay two
// - Close drives relay one, stop relay three
// - Shutdown command drives relay four
// - Partial stroke command zero off, nonzero on
// - Pulse count 0 to 9999 binary
`timescale 1ns/10ps
module vu_param_bank
	import vu_pkg::*;
#(
	parameter int SEC_COUNT = SEC_CYCLES // Cycles per second, shorten in simulation
)(
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Parameter access port
	input  wire logic              param_req,
	input  wire logic              param_wr,
	input  wire logic [BLK_W-1:0]  param_block,
	input  wire logic [PAR_W-1:0]  param_index,
	input  wire logic [WORD_W-1:0] param_wdata,
	output logic [WORD_W-1:0]      param_rdata,
	output logic                   param_ack,
	// Field inputs (asynchronous)
	input  wire logic [MV_W-1:0]   measured_value_in,
	input  wire logic [WORD_W-1:0] raw_input_in,
	input  wire logic              relay_action_mode_in,
	input  wire logic              pulse_in,
	// Relay outputs
	output logic                   relay_one,
	output logic                   relay_two,
	output logic                   relay_three,
	output logic                   relay_four,
	output logic                   partial_stroke_test,
	// Control settings and report
	output logic [WORD_W-1:0]      target_position,
	output logic [WORD_W-1:0]      motion_hold_time,
	output logic [WORD_W-1:0]      position_deadband,
	output logic [WORD_W-1:0]      hysteresis,
	output logic [WORD_W-1:0]      position_cal_low,
	output logic [WORD_W-1:0]      position_cal_high,
	output logic                   position_report
);
	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	// Any non-zero write energises a relay, 16'hff00 included
	// Shared by all five command words so their decode cannot drift apart
	function automatic logic energise(input logic [WORD_W-1:0] w);
		return w != WORD_ZERO;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [MV_W-1:0]   mv_s1_ff, mv_s2_ff;     // Position synchroniser
	logic [WORD_W-1:0] raw_s1_ff, raw_s2_ff;   // Raw input synchroniser
	logic              mode_s1_ff, mode_s2_ff; // Relay mode synchroniser
	logic              pls_s1_ff, pls_s2_ff;   // Pulse synchroniser
	logic [WORD_W-1:0] dev_ff, nxt_dev;        // Deviation threshold
	logic [WORD_W-1:0] tmo_ff, nxt_tmo;        // Update timeout
	logic [WORD_W-1:0] cal_lo_ff, nxt_cal_lo;  // Low calibration point
	logic [WORD_W-1:0] cal_hi_ff, nxt_cal_hi;  // High calibration point
	logic [WORD_W-1:0] target_ff, nxt_target;  // Target position
	logic [WORD_W-1:0] hold_ff, nxt_hold;      // Motion hold time
	logic [WORD_W-1:0] dband_ff, nxt_dband;    // Deadband
	logic [WORD_W-1:0] hyst_ff, nxt_hyst;      // Hysteresis
	logic              r1_ff, nxt_r1;          // Relay one
	logic              r2_ff, nxt_r2;          // Relay two
	logic              r3_ff, nxt_r3;          // Relay three
	logic              r4_ff, nxt_r4;          // Relay four
	logic              pst_ff, nxt_pst;        // Partial stroke relay
	logic [WORD_W-1:0] rdata_ff, nxt_rdata;    // Read answer
	logic              ack_ff, nxt_ack;        // Access acknowledge
	logic [WORD_W-1:0] relay_word;             // Assembled relay state
	logic [WORD_W-1:0] pulse_count;            // Counter value
	logic [ADR_W-1:0]  addr;                   // Combined parameter address
	logic              wr_en;                  // Write strobe this cycle

	// Position link to the report engine; the bank drives the words
	vu_pos_if pos ();

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Multi-bit words are only two-flop synchronised; a word that changes
	// while sampled may read mixed for one cycle, acceptable for slow sensors
	// Only the second flop of each chain is read by any logic
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mv_s1_ff   <= 8'h00;
			mv_s2_ff   <= 8'h00;
			raw_s1_ff  <= 16'h0000;
			raw_s2_ff  <= 16'h0000;
			mode_s1_ff <= 1'b0;
			mode_s2_ff <= 1'b0;
			pls_s1_ff  <= 1'b0;
			pls_s2_ff  <= 1'b0;
		end
		else
		begin
			mv_s1_ff   <= measured_value_in;
			mv_s2_ff   <= mv_s1_ff;
			raw_s1_ff  <= raw_input_in;
			raw_s2_ff  <= raw_s1_ff;
			mode_s1_ff <= relay_action_mode_in;
			mode_s2_ff <= mode_s1_ff;
			pls_s1_ff  <= pulse_in;
			pls_s2_ff  <= pls_s1_ff;
		end
	end

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	// Report engine sees the synchronised position and the stored limits
	assign pos.measured_value = mv_s2_ff;
	assign pos.threshold      = dev_ff;
	assign pos.timeout        = tmo_ff;

	vu_pos_report #(
		.SEC_COUNT (SEC_COUNT)
	) u_report (
		.core_clk (core_clk),
		.rst      (rst),
		.pos      (pos.engine)
	);

	// Counter edge detector starts low, matching the idle pulse pin
	vu_pulse_counter u_counter (
		.core_clk   (core_clk),
		.rst        (rst),
		.pulse_sync (pls_s2_ff),
		.count      (pulse_count)
	);

	// ----------------------------------------
	// Relay state word
	// ----------------------------------------
	always_comb
	begin
		// Bits 4 to 6 and the upper byte stay zero
		relay_word                = WORD_ZERO; // Unused bits read zero
		relay_word[RLY_BIT_FOUR]  = r4_ff;
		relay_word[RLY_BIT_ONE]   = r1_ff;
		relay_word[RLY_BIT_THREE] = r3_ff;
		relay_word[RLY_BIT_TWO]   = r2_ff;
		relay_word[RLY_BIT_MODE]  = mode_s2_ff;
	end

	// ----------------------------------------
	// Write decode and next values
	// ----------------------------------------
	always_comb
	begin
		addr       = {param_block, param_index};
		wr_en      = param_req && param_wr;
		nxt_dev    = dev_ff;
		nxt_tmo    = tmo_ff;
		nxt_cal_lo = cal_lo_ff;
		nxt_cal_hi = cal_hi_ff;
		nxt_target = target_ff;
		nxt_hold   = hold_ff;
		nxt_dband  = dband_ff;
		nxt_hyst   = hyst_ff;
		nxt_r1     = r1_ff;
		nxt_r2     = r2_ff;
		nxt_r3     = r3_ff;
		nxt_r4     = r4_ff;
		nxt_pst    = pst_ff;
		// Writes land at the taking edge, so a read one cycle later sees them
		if (wr_en)
		begin
			unique case (addr)
				ADR_POS_DEV:    nxt_dev    = param_wdata;
				ADR_POS_TMO:    nxt_tmo    = param_wdata;
				ADR_POS_CAL_LO: nxt_cal_lo = param_wdata;
				ADR_POS_CAL_HI: nxt_cal_hi = param_wdata;
				ADR_CTL_TARGET: nxt_target = param_wdata;
				ADR_CTL_HOLD:   nxt_hold   = param_wdata;
				ADR_CTL_DBAND:  nxt_dband  = param_wdata;
				ADR_CTL_HYST:   nxt_hyst   = param_wdata;
				// A relay keeps its state until its next command word
				ADR_RLY_OPEN:   nxt_r2     = energise(param_wdata);
				ADR_RLY_CLOSE:  nxt_r1     = energise(param_wdata);
				ADR_RLY_STOP:   nxt_r3     = energise(param_wdata);
				ADR_RLY_ESD:    nxt_r4     = energise(param_wdata);
				ADR_RLY_PST:    nxt_pst    = energise(param_wdata);
				// Read-only and reserved words keep their state
				default:        nxt_hyst   = hyst_ff;
			endcase
		end
		// Every request is answered, whatever its address
		nxt_ack = param_req;
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	// Write-only commands read back zero, like reserved words
	// Registered so the answer stands in the same cycle as the acknowledge
	always_comb
	begin
		// Read data clears each cycle so no stale answer lingers
		nxt_rdata = WORD_ZERO;
		if (param_req && !param_wr)
		begin
			unique case ({param_block, param_index})
				ADR_POS_MV:      nxt_rdata = {8'h00, mv_s2_ff};
				ADR_POS_DEV:     nxt_rdata = dev_ff;
				ADR_POS_TMO:     nxt_rdata = tmo_ff;
				ADR_POS_CAL_LO:  nxt_rdata = cal_lo_ff;
				ADR_POS_CAL_HI:  nxt_rdata = cal_hi_ff;
				ADR_POS_RAW:     nxt_rdata = raw_s2_ff;
				ADR_CTL_TARGET:  nxt_rdata = target_ff;
				ADR_CTL_HOLD:    nxt_rdata = hold_ff;
				ADR_CTL_DBAND:   nxt_rdata = dband_ff;
				ADR_CTL_HYST:    nxt_rdata = hyst_ff;
				ADR_RLY_STATE:   nxt_rdata = relay_word;
				ADR_PULSE_COUNT: nxt_rdata = pulse_count;
				default:         nxt_rdata = WORD_ZERO;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Relays come up de-energised so nothing moves before the master writes
	// Calibration words are stored only; scaling is left to the master
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			dev_ff    <= 16'h0000;
			tmo_ff    <= 16'h0000;
			cal_lo_ff <= 16'h0000;
			cal_hi_ff <= 16'h0000;
			target_ff <= 16'h0000;
			hold_ff   <= 16'h0000;
			dband_ff  <= 16'h0000;
			hyst_ff   <= 16'h0000;
			r1_ff     <= 1'b0;
			r2_ff     <= 1'b0;
			r3_ff     <= 1'b0;
			r4_ff     <= 1'b0;
			pst_ff    <= 1'b0;
			rdata_ff  <= 16'h0000;
			ack_ff    <= 1'b0;
		end
		else
		begin
			dev_ff    <= nxt_dev;
			tmo_ff    <= nxt_tmo;
			cal_lo_ff <= nxt_cal_lo;
			cal_hi_ff <= nxt_cal_hi;
			target_ff <= nxt_target;
			hold_ff   <= nxt_hold;
			dband_ff  <= nxt_dband;
			hyst_ff   <= nxt_hyst;
			r1_ff     <= nxt_r1;
			r2_ff     <= nxt_r2;
			r3_ff     <= nxt_r3;
			r4_ff     <= nxt_r4;
			pst_ff    <= nxt_pst;
			rdata_ff  <= nxt_rdata;
			ack_ff    <= nxt_ack;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	// Control words leave unscaled; the actuator applies its own ranges
	assign param_rdata         = rdata_ff;
	assign param_ack           = ack_ff;
	assign relay_one           = r1_ff;
	assign relay_two           = r2_ff;
	assign relay_three         = r3_ff;
	assign relay_four          = r4_ff;
	assign partial_stroke_test = pst_ff;
	assign target_position     = target_ff;
	assign motion_hold_time    = hold_ff;
	assign position_deadband   = dband_ff;
	assign hysteresis          = hyst_ff;
	assign position_cal_low    = cal_lo_ff;
	assign position_cal_high   = cal_hi_ff;
	assign position_report     = pos.report;
endmodule // vu_param_bank

// ---- dv/vu_param_bank_asserts.sv ----
// Port-level checks of the valve unit parameter bank
`timescale 1ns/10ps
module vu_param_bank_asserts
	import vu_pkg::*;
(
	// Clock and reset
	input wire logic              core_clk,
	input wire logic              rst,
	// Parameter access port
	input wire logic              param_req,
	input wire logic              param_wr,
	input wire logic [BLK_W-1:0]  param_block,
	input wire logic [PAR_W-1:0]  param_index,
	input wire logic [WORD_W-1:0] param_wdata,
	input wire logic [WORD_W-1:0] param_rdata,
	input wire logic              param_ack,
	// Relay outputs and stored words
	input wire logic              relay_one,
	input wire logic              relay_two,
	input wire logic              relay_three,
	input wire logic              relay_four,
	input wire logic              partial_stroke_test,
	input wire logic [WORD_W-1:0] target_position
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	wire logic [ADR_W-1:0] adr    = {param_block, param_index}; // Address being taken
	wire logic             wr_now = param_req && param_wr;      // Write taken this edge
	wire logic             rd_now = param_req && !param_wr;     // Read taken this edge
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	ack_follows_req_a: assert property (param_req |=> param_ack)
		else $error("request not answered next cycle");
	ack_needs_req_a: assert property (param_ack |-> $past(param_req))
		else $error("answer without request");
	open_relay_two_a: assert property ((wr_now && adr == ADR_RLY_OPEN) |=>
		relay_two == ($past(param_wdata) != WORD_ZERO)) else $error("open command wrong");
	stop_relay_three_a: assert property ((wr_now && adr == ADR_RLY_STOP) |=>
		relay_three == ($past(param_wdata) != WORD_ZERO)) else $error("stop command wrong");
	close_relay_one_a: assert property ((wr_now && adr == ADR_RLY_CLOSE) |=>
		relay_one == ($past(param_wdata) != WORD_ZERO)) else $error("close command wrong");
	shutdown_relay_a: assert property ((wr_now && adr == ADR_RLY_ESD) |=>
		relay_four == ($past(param_wdata) != WORD_ZERO)) else $error("shutdown command wrong");
	stroke_test_a: assert property ((wr_now && adr == ADR_RLY_PST) |=>
		partial_stroke_test == ($past(param_wdata) != WORD_ZERO)) else $error("stroke test wrong");
	target_store_a: assert property ((wr_now && adr == ADR_CTL_TARGET) |=>
		target_position == $past(param_wdata)) else $error("target not stored");
	reserved_zero_a: assert property ((rd_now && adr == 7'h28) |=>
		param_rdata == WORD_ZERO) else $error("reserved read not zero");
	state_layout_a: assert property (rd_now && adr == ADR_RLY_STATE |=>
		param_rdata[6:0] == {3'h0, relay_two, relay_three, relay_one, relay_four}
		&& param_rdata[15:8] == 8'h00) else $error("relay state layout wrong");
endmodule // vu_param_bank_asserts

// ---- dv/vu_master_model.sv ----
// Master station model issuing single parameter accesses
`timescale 1ns/10ps
module vu_master_model
	import vu_pkg::*;
(
	// Clock and answer
	input wire logic        core_clk,
	input wire logic        param_ack,
	// Request side
	output logic              param_req,
	output logic              param_wr,
	output logic [BLK_W-1:0]  param_block,
	output logic [PAR_W-1:0]  param_index,
	output logic [WORD_W-1:0] param_wdata
);
	// Idle at time zero
	initial
	begin
		param_req = 1'b0;
		param_wr = 1'b0;
		{param_block, param_index} = '0;
		param_wdata = WORD_ZERO;
	end
	// One-cycle request pulse, then a bounded wait for the answer
	task automatic access(input logic w, input logic [ADR_W-1:0] a, input logic [WORD_W-1:0] d);
		int n;
		@(posedge core_clk);
		#1;
		param_req = 1'b1;
		param_wr = w;
		{param_block, param_index} = a;
		param_wdata = d;
		@(posedge core_clk);
		#1;
		param_req = 1'b0;
		// Released lines show the inverse so stale values are never trusted
		param_wr = ~w;
		{param_block, param_index} = ~a;
		param_wdata = ~d;
		n = 0;
		while (param_ack !== 1'b1 && n < 4)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask
endmodule // vu_master_model

// ---- dv/vu_param_bank_tb.sv ----
// Self-checking bench of the valve unit parameter bank
`timescale 1ns/10ps
module vu_param_bank_tb
	import vu_pkg::*;
;
	localparam int SECS = 10; // Short second keeps the timed report quick
	logic              core_clk, rst, param_req, param_wr, param_ack, pulse_in, relay_action_mode_in;
	logic              relay_one, relay_two, relay_three, relay_four, partial_stroke_test;
	logic              position_report;
	logic [BLK_W-1:0]  param_block;
	logic [PAR_W-1:0]  param_index;
	logic [MV_W-1:0]   measured_value_in;
	logic [WORD_W-1:0] param_wdata, param_rdata, raw_input_in, target_position, motion_hold_time;
	logic [WORD_W-1:0] position_deadband, hysteresis, position_cal_low, position_cal_high;
	logic [WORD_W-1:0] shadow [0:127]; // Stored words
	logic              rly [0:127];    // Relay command states
	logic [WORD_W-1:0] exp_q [$];      // Expected answers, oldest first
	logic [31:0]       seed = 32'h0000003f;
	int                err_count, checks_done, rep_n, pcount, g, rep0;
	logic [31:0]       r;
	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	vu_param_bank #(.SEC_COUNT(SECS)) u_dut (.core_clk, .rst, .param_req, .param_wr,
		.param_block, .param_index, .param_wdata, .param_rdata, .param_ack, .measured_value_in,
		.raw_input_in, .relay_action_mode_in, .pulse_in, .relay_one, .relay_two, .relay_three,
		.relay_four, .partial_stroke_test, .target_position, .motion_hold_time,
		.position_deadband, .hysteresis, .position_cal_low, .position_cal_high, .position_report);
	vu_master_model u_mst (.core_clk, .param_ack, .param_req, .param_wr, .param_block,
		.param_index, .param_wdata);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [WORD_W-1:0] exp_rd(input logic [ADR_W-1:0] a);
		case (a)
			ADR_POS_MV: return {8'h00, measured_value_in};
			ADR_POS_RAW: return raw_input_in;
			ADR_RLY_STATE: return {8'h00, relay_action_mode_in, 3'h0, rly[ADR_RLY_OPEN],
				rly[ADR_RLY_STOP], rly[ADR_RLY_CLOSE], rly[ADR_RLY_ESD]};
			ADR_PULSE_COUNT: return 16'(pcount);
			default: return shadow[a];
		endcase
	endfunction
	task automatic check(input string what, input logic [WORD_W-1:0] seen,
		input logic [WORD_W-1:0] want);
		checks_done++;
		if (seen !== want)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask
	// Note the expected answer, update the model, then make the access
	task automatic acc(input logic w, input logic [ADR_W-1:0] a, input logic [WORD_W-1:0] d);
		exp_q.push_back(w ? WORD_ZERO : exp_rd(a));
		if (w && a inside {ADR_POS_DEV, ADR_POS_TMO, ADR_POS_CAL_LO, ADR_POS_CAL_HI,
			ADR_CTL_TARGET, ADR_CTL_HOLD, ADR_CTL_DBAND, ADR_CTL_HYST})
			shadow[a] = d;
		if (w && a inside {[ADR_RLY_OPEN:ADR_RLY_PST]})
			rly[a] = (d != WORD_ZERO);
		u_mst.access(w, a, d);
	endtask
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			#1 pulse_in = 1'b1;
			pcount = (pcount + 1) % 10000;
			@(posedge core_clk);
			#1 pulse_in = 1'b0;
		end
		repeat (4) @(posedge core_clk);
	endtask
	task automatic gap_to_report(output int gap);
		int start;
		start = rep_n;
		gap = 0;
		while (rep_n == start && gap < 200)
		begin
			@(posedge core_clk);
			#1;
			gap++;
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Monitor: each answer takes the oldest note
	// ----------------------------------------
	always @(posedge core_clk)
	begin
		if (position_report === 1'b1)
			rep_n++;
		if (param_ack === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unasked answer", 16'h0001, WORD_ZERO);
			else
				check("read data", param_rdata, exp_q.pop_front());
		end
	end
	// Watchdog sized well beyond the roughly 21000 cycles of traffic
	initial
	begin
		#300000;
		err_count++;
		$display("unexpected watchdog expiry");
		tally_and_finish();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst = 1'b1;
		pulse_in = 1'b0;
		relay_action_mode_in = 1'b0;
		measured_value_in = 8'hff;
		raw_input_in = 16'(xs());
		for (int a = 0; a < 128; a++)
		begin
			shadow[a] = WORD_ZERO;
			rly[a] = 1'b0;
		end
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge core_clk);
		// Whole map after reset, reserved places included
		for (int a = 0; a < 128; a++)
			acc(1'b0, 7'(a), WORD_ZERO);
		// Maintained mode, new field values, then random traffic
		relay_action_mode_in = 1'b1;
		raw_input_in = 16'(xs());
		measured_value_in = 8'(xs());
		repeat (3) @(posedge core_clk);
		repeat (300)
		begin
			r = xs();
			acc(r[9], r[8] ? r[6:0] : (7'h20 | 7'(r[4:0])), r[10] ? WORD_ZERO : r[31:16]);
		end
		// Every relay command on, then off, checked at the pins
		for (int k = 0; k < 10; k++)
		begin
			acc(1'b1, ADR_RLY_OPEN + 7'(k % 5), (k < 5) ? 16'hff00 : WORD_ZERO);
			check("relays", {11'h000, partial_stroke_test, relay_four, relay_one, relay_three,
				relay_two}, {11'h000, rly[ADR_RLY_PST], rly[ADR_RLY_ESD], rly[ADR_RLY_CLOSE],
				rly[ADR_RLY_STOP], rly[ADR_RLY_OPEN]});
			acc(1'b0, ADR_RLY_STATE, WORD_ZERO);
		end
		// Full-scale control words
		for (int k = 0; k < 3; k++)
		begin
			acc(1'b1, ADR_CTL_TARGET + 7'(k), 16'h00ff);
			acc(1'b0, ADR_CTL_TARGET + 7'(k), WORD_ZERO);
		end
		check("target", target_position, shadow[ADR_CTL_TARGET]);
		check("hold", motion_hold_time, shadow[ADR_CTL_HOLD]);
		check("deadband", position_deadband, shadow[ADR_CTL_DBAND]);
		check("hysteresis", hysteresis, shadow[ADR_CTL_HYST]);
		check("cal low", position_cal_low, shadow[ADR_POS_CAL_LO]);
		check("cal high", position_cal_high, shadow[ADR_POS_CAL_HI]);
		// Counter at its top value, then across the wrap
		pulses(9999);
		acc(1'b0, ADR_PULSE_COUNT, WORD_ZERO);
		pulses(2);
		acc(1'b0, ADR_PULSE_COUNT, WORD_ZERO);
		// Both report triggers disabled
		measured_value_in = 8'h64;
		acc(1'b1, ADR_POS_DEV, WORD_ZERO);
		acc(1'b1, ADR_POS_TMO, WORD_ZERO);
		repeat (10) @(posedge core_clk);
		#1 rep0 = rep_n;
		repeat (100) @(posedge core_clk);
		check("idle reports", 16'(rep_n - rep0), WORD_ZERO);
		// Timed report every three seconds
		acc(1'b1, ADR_POS_TMO, 16'h0003);
		gap_to_report(g);
		gap_to_report(g);
		check("report gap", 16'(g >= 3 * SECS && g <= 3 * SECS + 1), 16'h0001);
		// Deviation just over and exactly at the threshold
		acc(1'b1, ADR_POS_TMO, WORD_ZERO);
		acc(1'b1, ADR_POS_DEV, 16'h0005);
		repeat (10) @(posedge core_clk);
		#1 rep0 = rep_n;
		measured_value_in = 8'h6a;
		repeat (10) @(posedge core_clk);
		check("deviation report", 16'(rep_n - rep0), 16'h0001);
		#1 measured_value_in = 8'h6f;
		repeat (20) @(posedge core_clk);
		check("threshold report", 16'(rep_n - rep0), 16'h0001);
		check("pending answers", 16'(exp_q.size()), WORD_ZERO);
		tally_and_finish();
	end
endmodule // vu_param_bank_tb
bind vu_param_bank vu_param_bank_asserts u_chk (.core_clk, .rst, .param_req, .param_wr,
	.param_block, .param_index, .param_wdata, .param_rdata, .param_ack, .relay_one,
	.relay_two, .relay_three, .relay_four, .partial_stroke_test, .target_position);
